// ---- include/dma_trig_pkg.sv ----
// Package with register map, trigger codes and carrier types of the DMA trigger channel
package dma_trig_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h01;
  localparam logic [7:0] OFS_TRIG_SEL = 8'h03;
  localparam logic [7:0] OFS_CNT_LO = 8'h04;
  localparam logic [7:0] OFS_CNT_HI = 8'h05;
  localparam logic [7:0] OFS_REPEAT = 8'h06;

  // Control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_REPEAT = 1;
  localparam int CTRL_SW_TRIG = 2;

  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_PEND = 1;
  localparam int STAT_DONE = 4;

  // Reset values
  localparam logic [7:0] RST_TRIG_SEL = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] RST_REPEAT = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Block counting constants
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_FULL = 16'hFFFF;
  localparam logic [7:0] REP_ZERO = 8'h00;
  localparam logic [7:0] REP_ONE = 8'h01;

  // Trigger source base codes and offset limits
  localparam logic [7:0] TRIG_OFF = 8'h00;
  localparam logic [7:0] EVT_BASE = 8'h01;
  localparam logic [7:0] EVT_LAST = 8'h02;
  localparam logic [7:0] AES_CODE = 8'h04;
  localparam logic [7:0] ADC_BASE_A = 8'h10;
  localparam logic [7:0] ADC_BASE_B = 8'h20;
  localparam logic [7:0] ADC_LAST = 8'h04;
  localparam logic [7:0] DAC_BASE_A = 8'h15;
  localparam logic [7:0] DAC_BASE_B = 8'h25;
  localparam logic [7:0] DAC_LAST = 8'h01;
  localparam logic [7:0] PORT_BASE = 8'h40;
  localparam logic [7:0] PORT_STRIDE = 8'h20;
  localparam logic [7:0] TC0_LAST = 8'h05;
  localparam logic [7:0] TC1_REL = 8'h06;
  localparam logic [7:0] TC1_LAST = 8'h03;
  localparam logic [7:0] SPI_REL = 8'h0A;
  localparam logic [7:0] USART0_REL = 8'h0B;
  localparam logic [7:0] USART1_REL = 8'h0E;
  localparam logic [7:0] USART_LAST = 8'h01;

  // One bit per trigger source of the device
  typedef struct packed {
    logic [2:0] evt;
    logic aes;
    logic [1:0][4:0] adc;
    logic [1:0][1:0] dac;
    logic [3:0][5:0] tc0;
    logic [3:0][3:0] tc1;
    logic [3:0] spi;
    logic [3:0][1:0][1:0] usart;
  } req_vec_t;

  // Channel state
  typedef enum logic {ST_IDLE, ST_BLOCK} chan_state_t;

endpackage : dma_trig_pkg

// ---- hdl/dma_channel_trigger.sv ----
// DMA channel trigger selection with block byte and repeat counting
// Function
// R01 - Select value zero ignores hardware requests; only software starts transfers.
// R02 - Select code is module base value plus request offset within module.
// R03 - Event system triggers use base 0x01, offsets 0 to 2.
// R04 - Encryption engine has single trigger code 0x04.
// R05 - Converter-in bases 0x10, 0x20; offsets 0-3 one channel, 4 all.
// R06 - Converter-out bases 0x15, 0x25; only offsets 0 and 1 valid.
// R07 - Timer offsets: wrap 0, error 1, compare A-D 2-5; C, D first only.
// R08 - First timer bases 0x40, 0x60, 0x80, 0xA0; second six above.
// R09 - Each port serial peripheral has one code: 0x4A, 0x6A, 0x8A, 0xAA.
// R10 - Transceiver bases 0x4B, 0x4E; offset 0 receive, 1 transmit empty.
// R11 - Code of an absent peripheral produces no trigger.
// R12 - Pending request dropped when source flag cleared or interrupt taken.
// R13 - Serving a request may clear the source interrupt flag.
// R14 - Source withdraws request when its register is accessed.
// R15 - Block byte count is 16 bits from low and high byte registers.
// R16 - Block byte count decrements by one after each byte read.
// R17 - Count reaching zero reloads last value software wrote.
// R18 - Zero loaded then triggered gives 0xFFFF transfers.
// R19 - Limited repeats: repeat count decrements after each completed block.
// R20 - Repeat mode: channel disables when repeat count hits zero, block done.
// R21 - Repeat mode with repeat count zero means unlimited repeats.
// R22 - Unlimited repeat raises transaction done flag after every block.
// R23 - Selected hardware request held pending until served or withdrawn.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

module dma_channel_trigger #(
  parameter dma_trig_pkg::req_vec_t PRESENT = '1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire dma_trig_pkg::req_vec_t periph_req,
  input wire dma_trig_pkg::req_vec_t periph_drop,
  output dma_trig_pkg::req_vec_t periph_serve,
  output logic block_active,
  input wire logic byte_read,
  output logic block_end
);

  // Software visible state
  logic enable_r;
  logic repeat_mode_r;
  logic done_flag_r;
  logic [7:0] trig_sel_r;
  logic [15:0] count_reload_r;
  logic [15:0] count_r;
  logic [7:0] repeat_r;
  logic [7:0] rdata_nxt;

  // Trigger state
  dma_trig_pkg::chan_state_t state_r;
  dma_trig_pkg::req_vec_t sel_mask;
  dma_trig_pkg::req_vec_t serve_r;
  logic sel_req;
  logic sel_req_d_r;
  logic pend_r;
  logic sel_drop;
  logic sw_trig;
  logic hw_start;
  logic start;
  logic last_byte;
  logic txn_end;
  logic flag_block;

  // Map a select code onto the one source it names
  function automatic dma_trig_pkg::req_vec_t decode(input logic [7:0] code);
    dma_trig_pkg::req_vec_t m;
    logic [7:0] base;
    logic [7:0] off;
    m = '0;
    base = dma_trig_pkg::EVT_BASE;
    off = code - base;
    // Event routing channels
    if (code >= base && off <= dma_trig_pkg::EVT_LAST) // see R03
      m.evt[off[1:0]] = 1'b1;
    if (code == dma_trig_pkg::AES_CODE) // see R04
      m.aes = 1'b1;
    for (int a = 0; a < 2; a++)
    begin
      base = (a == 0) ? dma_trig_pkg::ADC_BASE_A : dma_trig_pkg::ADC_BASE_B;
      off = code - base;
      if (code >= base && off <= dma_trig_pkg::ADC_LAST) // see R05
        m.adc[a][off[2:0]] = 1'b1;
      base = (a == 0) ? dma_trig_pkg::DAC_BASE_A : dma_trig_pkg::DAC_BASE_B;
      off = code - base;
      if (code >= base && off <= dma_trig_pkg::DAC_LAST) // see R06
        m.dac[a][off[0]] = 1'b1;
    end
    for (int p = 0; p < 4; p++)
    begin
      // Port base is base plus sum of offsets, see R02
      base = dma_trig_pkg::PORT_BASE + 8'(p) * dma_trig_pkg::PORT_STRIDE; // see R08
      off = code - base;
      if (code >= base && off <= dma_trig_pkg::TC0_LAST) // see R07
        m.tc0[p][off[2:0]] = 1'b1;
      off = code - base - dma_trig_pkg::TC1_REL;
      if (code >= base + dma_trig_pkg::TC1_REL && off <= dma_trig_pkg::TC1_LAST) // see R07
        m.tc1[p][off[1:0]] = 1'b1;
      if (code == base + dma_trig_pkg::SPI_REL) // see R09
        m.spi[p] = 1'b1;
      off = code - base - dma_trig_pkg::USART0_REL;
      if (code >= base + dma_trig_pkg::USART0_REL && off <= dma_trig_pkg::USART_LAST)
        m.usart[p][0][off[0]] = 1'b1; // see R10
      off = code - base - dma_trig_pkg::USART1_REL;
      if (code >= base + dma_trig_pkg::USART1_REL && off <= dma_trig_pkg::USART_LAST)
        m.usart[p][1][off[0]] = 1'b1; // see R10
    end
    return m;
  endfunction : decode

  // Selected source, blanked when off or absent
  always_comb
  begin
    sel_mask = decode(trig_sel_r) & PRESENT; // see R11
    sel_req = |(sel_mask & periph_req);
    sel_drop = |(sel_mask & periph_drop);
    if (trig_sel_r == dma_trig_pkg::TRIG_OFF) // see R01
    begin
      sel_req = 1'b0;
      sel_drop = 1'b0;
    end
  end

  // Start and end conditions of a block
  assign sw_trig = reg_wr && reg_addr == dma_trig_pkg::OFS_CTRL
                   && reg_wdata[dma_trig_pkg::CTRL_SW_TRIG];
  assign hw_start = pend_r && sel_req;
  assign start = enable_r && state_r == dma_trig_pkg::ST_IDLE && (sw_trig || hw_start);
  assign last_byte = state_r == dma_trig_pkg::ST_BLOCK && byte_read
                     && count_r == dma_trig_pkg::CNT_ONE;
  assign flag_block = last_byte && (!repeat_mode_r || repeat_r == dma_trig_pkg::REP_ZERO
                      || repeat_r == dma_trig_pkg::REP_ONE); // see R22
  assign txn_end = last_byte && (!repeat_mode_r || repeat_r == dma_trig_pkg::REP_ONE); // see R20
  assign block_active = state_r == dma_trig_pkg::ST_BLOCK;
  assign block_end = last_byte;
  assign periph_serve = serve_r;

  // Channel state machine
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state_r <= dma_trig_pkg::ST_IDLE;
    else
    begin
      case (state_r)
        dma_trig_pkg::ST_IDLE:
          if (start)
            state_r <= dma_trig_pkg::ST_BLOCK;
        dma_trig_pkg::ST_BLOCK:
          if (last_byte)
            state_r <= dma_trig_pkg::ST_IDLE;
        default:
          state_r <= dma_trig_pkg::ST_IDLE;
      endcase
    end
  end

  // Pending hardware request
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pend_r <= 1'b0;
      sel_req_d_r <= 1'b0;
    end
    else
    begin
      sel_req_d_r <= sel_req;
      if (!sel_req || sel_drop) // see R12, R14
        pend_r <= 1'b0;
      else if (start && hw_start)
        pend_r <= 1'b0;
      else if (!sel_req_d_r) // see R23
        pend_r <= 1'b1;
    end
  end

  // Serve pulse lets the source clear its flag
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      serve_r <= '0;
    else if (start && hw_start && !sw_trig)
      serve_r <= sel_mask; // see R13
    else
      serve_r <= '0;
  end

  // Control register and hardware disable
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      enable_r <= 1'b0;
      repeat_mode_r <= 1'b0;
    end
    else if (reg_wr && reg_addr == dma_trig_pkg::OFS_CTRL)
    begin
      enable_r <= reg_wdata[dma_trig_pkg::CTRL_ENABLE];
      repeat_mode_r <= reg_wdata[dma_trig_pkg::CTRL_REPEAT];
    end
    else if (txn_end)
      enable_r <= 1'b0; // see R20, R21
  end

  // Done flag, set wins over write-one clear
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      done_flag_r <= 1'b0;
    else if (flag_block)
      done_flag_r <= 1'b1; // see R22
    else if (reg_wr && reg_addr == dma_trig_pkg::OFS_STATUS
             && reg_wdata[dma_trig_pkg::STAT_DONE])
      done_flag_r <= 1'b0;
  end

  // Trigger select register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      trig_sel_r <= dma_trig_pkg::RST_TRIG_SEL;
    else if (reg_wr && reg_addr == dma_trig_pkg::OFS_TRIG_SEL)
      trig_sel_r <= reg_wdata; // see R02
  end

  // Block byte counter with reload copy
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      count_reload_r <= dma_trig_pkg::RST_COUNT;
      count_r <= dma_trig_pkg::RST_COUNT;
    end
    else if (reg_wr && reg_addr == dma_trig_pkg::OFS_CNT_LO)
    begin
      count_reload_r[7:0] <= reg_wdata; // see R15
      count_r[7:0] <= reg_wdata;
    end
    else if (reg_wr && reg_addr == dma_trig_pkg::OFS_CNT_HI)
    begin
      count_reload_r[15:8] <= reg_wdata; // see R15
      count_r[15:8] <= reg_wdata;
    end
    else if (start && count_r == dma_trig_pkg::CNT_ZERO)
      count_r <= dma_trig_pkg::CNT_FULL; // see R18
    else if (last_byte)
      count_r <= count_reload_r; // see R17
    else if (state_r == dma_trig_pkg::ST_BLOCK && byte_read)
      count_r <= count_r - dma_trig_pkg::CNT_ONE; // see R16
  end

  // Repeat counter
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      repeat_r <= dma_trig_pkg::RST_REPEAT;
    else if (reg_wr && reg_addr == dma_trig_pkg::OFS_REPEAT)
      repeat_r <= reg_wdata;
    else if (last_byte && repeat_mode_r && repeat_r != dma_trig_pkg::REP_ZERO)
      repeat_r <= repeat_r - dma_trig_pkg::REP_ONE; // see R19
  end

  // Read multiplexer
  always_comb
  begin
    rdata_nxt = dma_trig_pkg::ZERO_BYTE;
    case (reg_addr)
      dma_trig_pkg::OFS_CTRL:
      begin
        rdata_nxt[dma_trig_pkg::CTRL_ENABLE] = enable_r;
        rdata_nxt[dma_trig_pkg::CTRL_REPEAT] = repeat_mode_r;
      end
      dma_trig_pkg::OFS_STATUS:
      begin
        rdata_nxt[dma_trig_pkg::STAT_BUSY] = block_active;
        rdata_nxt[dma_trig_pkg::STAT_PEND] = pend_r;
        rdata_nxt[dma_trig_pkg::STAT_DONE] = done_flag_r;
      end
      dma_trig_pkg::OFS_TRIG_SEL: rdata_nxt = trig_sel_r;
      dma_trig_pkg::OFS_CNT_LO: rdata_nxt = count_r[7:0];
      dma_trig_pkg::OFS_CNT_HI: rdata_nxt = count_r[15:8];
      dma_trig_pkg::OFS_REPEAT: rdata_nxt = repeat_r;
      default: rdata_nxt = dma_trig_pkg::ZERO_BYTE;
    endcase
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      reg_rdata <= dma_trig_pkg::ZERO_BYTE;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= dma_trig_pkg::ZERO_BYTE;
  end

  // Checks on the channel behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_off_no_pend: assert property ( // see R01
    trig_sel_r == dma_trig_pkg::TRIG_OFF |=> !pend_r)
    else $error("pending set while trigger select is off");

  chk_serve_onehot: assert property ( // see R13
    $onehot0(serve_r) and (serve_r != '0 |-> !$past(block_active)))
    else $error("serve pulse not one-hot or not at block start");

  chk_hw_start: assert property ( // see R23
    pend_r && sel_req && enable_r && !block_active |=> block_active && !pend_r)
    else $error("pending request did not start a block");

  chk_done_clear: assert property ( // see R22
    !flag_block && reg_wr && reg_addr == dma_trig_pkg::OFS_STATUS
    && reg_wdata[dma_trig_pkg::STAT_DONE] |=> !done_flag_r)
    else $error("done flag not cleared by write of one");

  chk_single_block: assert property ( // see R22
    last_byte && !repeat_mode_r && !reg_wr |=> !enable_r && done_flag_r)
    else $error("single block did not end the transaction");

  chk_count_dec: assert property ( // see R16
    block_active && byte_read && count_r != dma_trig_pkg::CNT_ONE && !reg_wr
    |=> count_r == $past(count_r) - dma_trig_pkg::CNT_ONE)
    else $error("byte count did not decrement");

  chk_count_reload: assert property ( // see R17
    last_byte && !reg_wr |=> count_r == $past(count_reload_r))
    else $error("byte count not reloaded at block end");

  chk_zero_full: assert property ( // see R18
    start && count_r == dma_trig_pkg::CNT_ZERO && !reg_wr |=> count_r == dma_trig_pkg::CNT_FULL)
    else $error("zero count not turned into full count");

  chk_repeat_dec: assert property ( // see R19
    last_byte && repeat_mode_r && repeat_r > dma_trig_pkg::REP_ONE && !reg_wr
    |=> repeat_r == $past(repeat_r) - dma_trig_pkg::REP_ONE && enable_r)
    else $error("repeat count not decremented or channel dropped early");

  chk_repeat_end: assert property ( // see R20
    last_byte && repeat_mode_r && repeat_r == dma_trig_pkg::REP_ONE && !reg_wr
    |=> !enable_r && done_flag_r && repeat_r == dma_trig_pkg::REP_ZERO)
    else $error("channel not disabled at last repeat");

  chk_unlimited: assert property ( // see R21, R22
    last_byte && repeat_mode_r && repeat_r == dma_trig_pkg::REP_ZERO && !reg_wr
    |=> enable_r && done_flag_r)
    else $error("unlimited repeat ended or missed done flag");

  chk_drop_pend: assert property ( // see R12
    pend_r && sel_drop |=> !pend_r)
    else $error("pending kept after source drop");

  chk_pend_withdraw: assert property ( // see R14, R23
    !sel_req |=> !pend_r ##0 !hw_start)
    else $error("pending kept after request withdrawn");

  chk_rdata_once: assert property (
    !reg_rd |=> reg_rdata == dma_trig_pkg::ZERO_BYTE)
    else $error("read data stands outside its cycle");

  cov_hw_block: cover property (start && hw_start ##[1:300] last_byte);
  cov_sw_block: cover property (start && sw_trig ##[1:300] last_byte);
  cov_unlimited: cover property (flag_block && repeat_mode_r && !txn_end);
  cov_drop: cover property (pend_r && sel_drop);

endmodule : dma_channel_trigger

// ---- verification/periph_req_model.sv ----
// Request source model: peripherals raising and withdrawing trigger levels
`timescale 1ns/1ps
module periph_req_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clear_all,
  input wire dma_trig_pkg::req_vec_t raise,
  input wire dma_trig_pkg::req_vec_t periph_serve,
  output dma_trig_pkg::req_vec_t periph_req
);
  // Levels rise on command, fall once the channel serves them
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      periph_req <= '0;
    end
    else if (clear_all)
    begin
      periph_req <= '0;
    end
    else
    begin
      periph_req <= (periph_req | raise) & ~periph_serve;
    end
  end
endmodule : periph_req_model

// ---- verification/dma_channel_trigger_and_counts_tb.sv ----
// Self-checking bench for the DMA trigger channel
`timescale 1ns/1ps
module dma_channel_trigger_and_counts_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic byte_read = 1'b0;
  logic block_active;
  logic block_end;
  logic clear_all = 1'b0;
  logic act;
  logic [7:0] rv;
  logic [15:0] n;
  dma_trig_pkg::req_vec_t raise = '0;
  dma_trig_pkg::req_vec_t periph_drop = '0;
  dma_trig_pkg::req_vec_t periph_req;
  dma_trig_pkg::req_vec_t periph_serve;
  dma_trig_pkg::req_vec_t srv;
  int err_total = 0;
  int n_checks = 0;
  int idx;
  int reps[3] = '{0, 1, 3};
  // Second timer of the last port left out of this build
  localparam dma_trig_pkg::req_vec_t PRES = ~(78'hF << 32);

  always #4 mclk = ~mclk;

  dma_channel_trigger #(.PRESENT(PRES)) uut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
    .periph_drop(periph_drop), .periph_serve(periph_serve), .block_active(block_active),
    .byte_read(byte_read), .block_end(block_end)
  );

  periph_req_model far_end (
    .mclk(mclk), .reset(reset), .clear_all(clear_all), .raise(raise),
    .periph_serve(periph_serve), .periph_req(periph_req)
  );

  // Bit position of the request a select code names, -1 if none
  function automatic int exp_idx(input logic [7:0] c);
    int p;
    int r;
    exp_idx = -1;
    p = (c - 8'h40) >> 5;
    r = (c - 8'h40) & 31;
    if (c >= 8'h01 && c <= 8'h03) exp_idx = 74 + c;
    else if (c == 8'h04) exp_idx = 74;
    else if (c >= 8'h10 && c <= 8'h14) exp_idx = 64 + c - 8'h10;
    else if (c >= 8'h20 && c <= 8'h24) exp_idx = 69 + c - 8'h20;
    else if (c == 8'h15 || c == 8'h16) exp_idx = 60 + c - 8'h15;
    else if (c == 8'h25 || c == 8'h26) exp_idx = 62 + c - 8'h25;
    else if (c >= 8'h40 && p < 4)
    begin
      if (r < 6) exp_idx = 36 + p * 6 + r;
      else if (r < 10) exp_idx = 20 + p * 4 + r - 6;
      else if (r == 10) exp_idx = 16 + p;
      else if (r == 11 || r == 12) exp_idx = p * 4 + r - 11;
      else if (r == 14 || r == 15) exp_idx = p * 4 + r - 12;
    end
    if (exp_idx >= 32 && exp_idx <= 35) exp_idx = -1;
  endfunction : exp_idx

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(what, {8'h00, exp}, {8'h00, reg_rdata});
  endtask : rchk

  // Every request level dropped by the far end
  task automatic fresh_req();
    @(posedge mclk);
    clear_all <= 1'b1;
    @(posedge mclk);
    clear_all <= 1'b0;
  endtask : fresh_req

  task automatic wait_act();
    srv = '0;
    act = 1'b0;
    repeat (8)
    begin
      @(negedge mclk);
      if (periph_serve !== '0) srv = periph_serve;
      if (block_active === 1'b1) act = 1'b1;
    end
  endtask : wait_act

  // Bytes read back to back; only the last one ends the block
  task automatic run_block(input logic [15:0] cnt);
    for (int i = 1; i <= cnt; i++)
    begin
      @(posedge mclk);
      byte_read <= 1'b1;
      @(negedge mclk);
      chk("block_end", {15'h0, i == cnt}, {15'h0, block_end});
    end
    @(posedge mclk);
    byte_read <= 1'b0;
    @(negedge mclk);
    chk("block_active", 16'h0000, {15'h0, block_active});
  endtask : run_block

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // Hang guard, about a quarter above the expected run
  initial
  begin
    repeat (90000) @(posedge mclk);
    err_total++;
    close_out();
  end

  initial
  begin
    void'($urandom(82086));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    // Reset values, unmapped place, random write and read back
    for (int a = 0; a <= 6; a++) rchk("reset value", 8'(a), 8'h00);
    wr(8'h02, 8'h5A);
    rchk("unmapped", 8'h02, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      n = 16'($urandom);
      wr(dma_trig_pkg::OFS_TRIG_SEL, n[7:0]);
      wr(dma_trig_pkg::OFS_CNT_LO, n[7:0]);
      wr(dma_trig_pkg::OFS_CNT_HI, n[15:8]);
      rchk("select", dma_trig_pkg::OFS_TRIG_SEL, n[7:0]);
      rchk("count low", dma_trig_pkg::OFS_CNT_LO, n[7:0]);
      rchk("count high", dma_trig_pkg::OFS_CNT_HI, n[15:8]);
    end
    $display("test registers done");
    // Every select code with all request lines rising
    wr(dma_trig_pkg::OFS_CNT_LO, 8'h01);
    wr(dma_trig_pkg::OFS_CNT_HI, 8'h00);
    for (int c = 0; c < 256; c++)
    begin
      idx = exp_idx(8'(c));
      fresh_req();
      wr(dma_trig_pkg::OFS_TRIG_SEL, 8'(c));
      wr(dma_trig_pkg::OFS_CTRL, 8'h01);
      @(posedge mclk);
      raise <= '1;
      @(posedge mclk);
      raise <= '0;
      wait_act();
      chk("started", {15'h0, idx >= 0}, {15'h0, act});
      if (idx >= 0) chk("serve", 16'h0001, {15'h0, srv === (78'h1 << idx)});
      if (act === 1'b1) run_block(16'h0001);
    end
    $display("test select codes done");
    // Pending request dropped, or held until the channel is enabled
    for (int d = 0; d < 2; d++)
    begin
      fresh_req();
      wr(dma_trig_pkg::OFS_TRIG_SEL, 8'h4A);
      wr(dma_trig_pkg::OFS_CTRL, 8'h00);
      wr(dma_trig_pkg::OFS_STATUS, 8'h10);
      @(posedge mclk);
      raise <= '1;
      @(posedge mclk);
      raise <= '0;
      @(posedge mclk);
      periph_drop.spi[0] <= (d == 0);
      @(posedge mclk);
      periph_drop <= '0;
      rchk("pending bit", dma_trig_pkg::OFS_STATUS, {6'h00, d == 1, 1'b0});
      wr(dma_trig_pkg::OFS_CTRL, 8'h01);
      wait_act();
      chk("pending kept", 16'(d), {15'h0, act});
      if (act === 1'b1) run_block(16'h0001);
    end
    $display("test pending done");
    // Repeat mode: limited, single and unlimited
    for (int t = 0; t < 3; t++)
    begin
      n = 16'($urandom_range(20, 2));
      wr(dma_trig_pkg::OFS_CNT_LO, n[7:0]);
      wr(dma_trig_pkg::OFS_CNT_HI, n[15:8]);
      wr(dma_trig_pkg::OFS_TRIG_SEL, 8'h00);
      wr(dma_trig_pkg::OFS_REPEAT, 8'(reps[t]));
      wr(dma_trig_pkg::OFS_CTRL, 8'h03);
      for (int b = 0; b < ((reps[t] == 0) ? 3 : reps[t]); b++)
      begin
        wr(dma_trig_pkg::OFS_CTRL, 8'h07);
        wait_act();
        chk("soft start", 16'h0001, {15'h0, act});
        run_block(n);
        rchk("count reload", dma_trig_pkg::OFS_CNT_LO, n[7:0]);
        rchk("repeat count", dma_trig_pkg::OFS_REPEAT, 8'((reps[t] == 0) ? 0 : reps[t] - b - 1));
        rchk("enable", dma_trig_pkg::OFS_CTRL, {7'h01, reps[t] == 0 || b < reps[t] - 1});
        rchk("done flag", dma_trig_pkg::OFS_STATUS, {3'h0, reps[t] == 0 || b == reps[t] - 1, 4'h0});
        wr(dma_trig_pkg::OFS_STATUS, 8'h10);
      end
    end
    $display("test repeat done");
    // Zero count runs the full span of bytes
    wr(dma_trig_pkg::OFS_CNT_LO, 8'h00);
    wr(dma_trig_pkg::OFS_CNT_HI, 8'h00);
    wr(dma_trig_pkg::OFS_CTRL, 8'h01);
    wr(dma_trig_pkg::OFS_CTRL, 8'h05);
    wait_act();
    chk("zero start", 16'h0001, {15'h0, act});
    run_block(16'hFFFF);
    rchk("zero reload", dma_trig_pkg::OFS_CNT_HI, 8'h00);
    $display("test zero count done");
    close_out();
  end
endmodule : dma_channel_trigger_and_counts_tb
